// ### verilog/rrl_ctrl_regs.sv
// reset control and link role/speed control registers of the repeater
// assumes a register port from the serial management target, one request
// per cycle, and link negotiation events as single-cycle pulses
`timescale 1ns/1ps
module rrl_ctrl_regs (
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    // register port
    input  wire rrl_pkg::rrl_reg_req_t req_i,
    output logic [7:0]                 rdata_o,
    output logic                       rvalid_o,
    // link configuration messages
    input  wire logic                  cfg_msg_i,
    input  wire logic                  cfg_host_i,
    output logic                       cfg_ack_o,
    // control towards the repeater core
    output logic                       soft_rst_o,
    output logic                       lsfs_only_o,
    output logic [2:0]                 opmode_o,
    output logic                       cd_enter_o,
    output logic                       role_host_o,
    output logic                       role_dev_o
);

    rrl_pkg::rrl_link_ctrl_t link_q;
    rrl_pkg::rrl_link_ctrl_t link_d;
    rrl_pkg::rrl_role_st_t   role_q;
    rrl_pkg::rrl_role_st_t   role_d;
    logic                    swrst_q;
    logic                    cd_q;
    logic                    ack_q;
    logic [7:0]              rdata_q;
    logic                    rvalid_q;
    logic                    wr_reset;
    logic                    wr_link;
    logic                    cd_req;
    logic                    forced;

    function automatic logic one_role_bit(input logic [1:0] r);
        one_role_bit = (r == rrl_pkg::RRL_ROLE_HOST) ||
                       (r == rrl_pkg::RRL_ROLE_DEV);
    endfunction : one_role_bit

    assign wr_reset = req_i.wr && (req_i.addr == rrl_pkg::RRL_OFS_RESET_CTRL);
    assign wr_link  = req_i.wr && (req_i.addr == rrl_pkg::RRL_OFS_LINK_CTRL);

    // a mode-2 write with an ambiguous role field has no target to jump to
    assign cd_req = wr_link && !swrst_q &&
        (req_i.wdata[2:0] == rrl_pkg::RRL_OPMODE_CD) &&
        one_role_bit(req_i.wdata[5:4]);

    assign forced = (link_q.opmode == rrl_pkg::RRL_OPMODE_CD) &&
                    one_role_bit(link_q.role);

    // software reset: one-cycle pulse, bit never holds
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            swrst_q <= rrl_pkg::RRL_RESET_CTRL_RST[rrl_pkg::RRL_SWRST_BIT];
        end else begin
            // a zero write leaves it alone; the pulse drops on its own
            swrst_q <= wr_reset &&
                req_i.wdata[rrl_pkg::RRL_SWRST_BIT] && !swrst_q;
        end
    end

    always_comb begin
        link_d = link_q;
        if (swrst_q) begin
            link_d = rrl_pkg::RRL_LINK_CTRL_RST;
        end else if (wr_link) begin
            link_d      = req_i.wdata;
            link_d.rsvd = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_q <= rrl_pkg::RRL_LINK_CTRL_RST;
        end else begin
            link_q <= link_d;
        end
    end

    // effective role of the repeater
    always_comb begin
        role_d = role_q;
        unique case (role_q)
            rrl_pkg::RRL_ST_DUAL,
            rrl_pkg::RRL_ST_HOST,
            rrl_pkg::RRL_ST_DEV: begin
                if (swrst_q) begin
                    role_d = rrl_pkg::RRL_ST_DUAL;
                end else if (cd_req) begin
                    role_d = (req_i.wdata[5:4] == rrl_pkg::RRL_ROLE_HOST) ?
                        rrl_pkg::RRL_ST_HOST : rrl_pkg::RRL_ST_DEV;
                end else if (cfg_msg_i && !forced) begin
                    role_d = cfg_host_i ? rrl_pkg::RRL_ST_HOST
                                        : rrl_pkg::RRL_ST_DEV;
                end
            end
            default: role_d = rrl_pkg::RRL_ST_DUAL;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            role_q <= rrl_pkg::RRL_ST_DUAL;
        end else begin
            role_q <= role_d;
        end
    end

    // connect-detect entry acts only at the moment of the write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cd_q <= 1'b0;
        end else begin
            cd_q <= cd_req;
        end
    end

    // every configuration message is answered, forced role or not
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= cfg_msg_i;
        end
    end

    // read data registered; unmapped offsets read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= req_i.rd;
            if (req_i.rd) begin
                unique case (req_i.addr)
                    rrl_pkg::RRL_OFS_LINK_CTRL: rdata_q <= link_q;
                    default:                    rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign rdata_o     = rdata_q;
    assign rvalid_o    = rvalid_q;
    assign cfg_ack_o   = ack_q;
    assign soft_rst_o  = swrst_q;
    assign lsfs_only_o = (link_q.speed == rrl_pkg::RRL_SPEED_LSFS);
    assign opmode_o    = link_q.opmode;
    assign cd_enter_o  = cd_q;
    assign role_host_o = (role_q == rrl_pkg::RRL_ST_HOST);
    assign role_dev_o  = (role_q == rrl_pkg::RRL_ST_DEV);

    sequence s_swrst_write;
        req_i.wr && req_i.addr == rrl_pkg::RRL_OFS_RESET_CTRL &&
        req_i.wdata[0] && !soft_rst_o;
    endsequence

    sequence s_cd_host_write;
        req_i.wr && req_i.addr == rrl_pkg::RRL_OFS_LINK_CTRL &&
        req_i.wdata[2:0] == 3'h2 && req_i.wdata[5:4] == 2'h1 && !soft_rst_o;
    endsequence

    chk_swrst_one_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        s_swrst_write |=> soft_rst_o ##1 !soft_rst_o)
        else $error("software reset pulse not exactly one cycle");

    chk_swrst_restores: assert property (@(posedge clk_i) disable iff (rst_i)
        soft_rst_o |=> (opmode_o == 3'h0 && !lsfs_only_o && !role_host_o &&
                        !role_dev_o))
        else $error("software reset did not restore defaults");

    chk_swrst_zero_ign: assert property (@(posedge clk_i) disable iff (rst_i)
        (req_i.wr && req_i.addr == 8'h01 && !req_i.wdata[0]) |=> !soft_rst_o)
        else $error("zero write started a software reset");

    chk_reset_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (req_i.rd && req_i.addr == 8'h01) |=> (rvalid_o && rdata_o == 8'h00))
        else $error("reset control read not zero");

    chk_speed_field: assert property (@(posedge clk_i) disable iff (rst_i)
        (req_i.wr && req_i.addr == 8'h02 && !soft_rst_o) |=>
        (lsfs_only_o == ($past(req_i.wdata[7:6]) == 2'h1)))
        else $error("speed policy does not follow write");

    chk_cd_host_entry: assert property (@(posedge clk_i) disable iff (rst_i)
        s_cd_host_write |=> (cd_enter_o && role_host_o && opmode_o == 3'h2))
        else $error("connect-detect host entry missing");

    chk_forced_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        (role_dev_o && opmode_o == 3'h2 && $past(opmode_o) == 3'h2 &&
         link_q.role == rrl_pkg::RRL_ROLE_DEV &&
         !soft_rst_o && !req_i.wr && cfg_msg_i && cfg_host_i) |=> role_dev_o)
        else $error("forced device role overridden by link");

    chk_cfg_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg_msg_i |=> cfg_ack_o)
        else $error("configuration message not acknowledged");

    chk_dual_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        (opmode_o != 3'h2 && !soft_rst_o && !req_i.wr && cfg_msg_i) |=>
        (role_host_o == $past(cfg_host_i) && role_dev_o != $past(cfg_host_i)))
        else $error("dual role ignores link negotiation");

    chk_cd_one_shot: assert property (@(posedge clk_i) disable iff (rst_i)
        cd_enter_o |=> !cd_enter_o || $past(req_i.wr))
        else $error("connect-detect entry held without a write");

endmodule : rrl_ctrl_regs

// ### inc/rrl_pkg.sv
// package for the repeater reset and link control register bank
// assumes one 10 MHz clock and a byte-wide register port from the serial
// management target that sits in front of it
package rrl_pkg;

    // register offsets
    localparam logic [7:0] RRL_OFS_RESET_CTRL = 8'h01;
    localparam logic [7:0] RRL_OFS_LINK_CTRL  = 8'h02;

    // field positions in the reset control register
    localparam int RRL_SWRST_BIT = 0;

    // field positions in the link control register
    localparam int RRL_SPEED_LSB  = 6;
    localparam int RRL_ROLE_LSB   = 4;
    localparam int RRL_OPMODE_LSB = 0;

    // speed policy codes
    localparam logic [1:0] RRL_SPEED_AUTO  = 2'h0;
    localparam logic [1:0] RRL_SPEED_LSFS  = 2'h1;

    // role control codes
    localparam logic [1:0] RRL_ROLE_DUAL   = 2'h0;
    localparam logic [1:0] RRL_ROLE_HOST   = 2'h1;
    localparam logic [1:0] RRL_ROLE_DEV    = 2'h2;

    // operational mode codes
    localparam logic [2:0] RRL_OPMODE_AUTO = 3'h0;
    localparam logic [2:0] RRL_OPMODE_CD   = 3'h2;

    // values after power-on or software reset
    localparam logic [7:0] RRL_RESET_CTRL_RST = 8'h00;
    localparam logic [7:0] RRL_LINK_CTRL_RST  = 8'h00;

    // cycles of the internal software reset pulse
    localparam int RRL_SWRST_CYCLES = 1;

    typedef struct packed {
        logic [1:0] speed;
        logic [1:0] role;
        logic       rsvd;
        logic [2:0] opmode;
    } rrl_link_ctrl_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rrl_reg_req_t;

    typedef enum logic [2:0] {
        RRL_ST_DUAL = 3'b001,
        RRL_ST_HOST = 3'b010,
        RRL_ST_DEV  = 3'b100
    } rrl_role_st_t;

endpackage : rrl_pkg

// ### sim/rrl_host_model.sv
// host controller model: single-byte register requests, one per call
// assumes the bench owns the clock and calls xfer from one process only
`timescale 1ns/1ps
module rrl_host_model (
    // clock
    input  wire logic             clk_i,
    // register port
    output rrl_pkg::rrl_reg_req_t req_o
);
    initial req_o = '0;

    // a released port shows inverted address and data, never the old byte
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d);
        @(negedge clk_i);
        req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge clk_i);
        req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : xfer
endmodule : rrl_host_model

// ### sim/testbench.sv
// self-checking bench for the reset and link control register bank
// assumes the host model drives the register port at falling edges
`timescale 1ns/1ps
module testbench;
    logic                  clk_i;
    logic                  rst_i;
    rrl_pkg::rrl_reg_req_t req;
    logic [7:0]            rdata_o;
    logic                  rvalid_o;
    logic                  cfg_msg_i;
    logic                  cfg_host_i;
    logic                  cfg_ack_o;
    logic                  soft_rst_o;
    logic                  lsfs_only_o;
    logic [2:0]            opmode_o;
    logic                  cd_enter_o;
    logic                  role_host_o;
    logic                  role_dev_o;
    int                    mismatches = 0;
    int                    n_tests = 0;
    // write data, expected read back, expected low/full-only flag
    localparam logic [16:0] ROWS [5] = '{{8'h00, 8'h00, 1'h0},
        {8'h40, 8'h40, 1'h1}, {8'h80, 8'h80, 1'h0},
        {8'hc9, 8'hc1, 1'h0}, {8'h22, 8'h22, 1'h0}};

    rrl_host_model host_model_inst (.clk_i(clk_i), .req_o(req));
    rrl_ctrl_regs rrl_ctrl_regs_inst (.clk_i(clk_i), .rst_i(rst_i),
        .req_i(req), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .cfg_msg_i(cfg_msg_i), .cfg_host_i(cfg_host_i),
        .cfg_ack_o(cfg_ack_o), .soft_rst_o(soft_rst_o),
        .lsfs_only_o(lsfs_only_o), .opmode_o(opmode_o),
        .cd_enter_o(cd_enter_o), .role_host_o(role_host_o),
        .role_dev_o(role_dev_o));

    initial clk_i = 1'b0;
    always #50 clk_i = ~clk_i;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_model_inst.xfer(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host_model_inst.xfer(1'b0, a, 8'h00);
        chk({7'h00, rvalid_o}, 8'h01);
        chk(rdata_o, e);
    endtask : rd_chk

    // message is taken at one edge, ack and role show one cycle on
    task automatic cfg(input logic host);
        @(negedge clk_i);
        cfg_msg_i = 1'b1;
        cfg_host_i = host;
        @(negedge clk_i);
        cfg_msg_i = 1'b0;
        cfg_host_i = ~host;
        chk({7'h00, cfg_ack_o}, 8'h01);
    endtask : cfg

    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        // whole run is about 70 cycles; this is far beyond it
        #200000;
        mismatches++;
        tally_and_finish();
    end

    initial begin
        rst_i = 1'b1;
        cfg_msg_i = 1'b0;
        cfg_host_i = 1'b0;
        repeat (12) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        chk({opmode_o, role_host_o, role_dev_o}, 8'h00);
        rd_chk(8'h02, 8'h00);
        foreach (ROWS[i]) begin
            wr(8'h02, ROWS[i][16:9]);
            chk({7'h00, lsfs_only_o}, {7'h00, ROWS[i][0]});
            chk({5'h00, opmode_o}, {5'h00, ROWS[i][11:9]});
            rd_chk(8'h02, ROWS[i][8:1]);
        end
        rd_chk(8'h05, 8'h00);
        // forced host or device ignores the opposite request but still acknowledges
        wr(8'h02, 8'h12);
        chk({cd_enter_o, role_host_o, role_dev_o}, 8'h06);
        cfg(1'b0);
        chk({6'h00, role_host_o, role_dev_o}, 8'h02);
        wr(8'h02, 8'h22);
        chk({cd_enter_o, role_host_o, role_dev_o}, 8'h05);
        cfg(1'b1);
        chk({6'h00, role_host_o, role_dev_o}, 8'h01);
        // dual role in auto mode: no entry pulse, role follows the link
        wr(8'h02, 8'h00);
        chk({7'h00, cd_enter_o}, 8'h00);
        cfg(1'b1);
        chk({6'h00, role_host_o, role_dev_o}, 8'h02);
        cfg(1'b0);
        chk({6'h00, role_host_o, role_dev_o}, 8'h01);
        // software reset: zero write is inert, one write pulses once
        wr(8'h02, 8'h41);
        wr(8'h01, 8'h00);
        chk({7'h00, soft_rst_o}, 8'h00);
        chk({5'h00, opmode_o}, 8'h01);
        rd_chk(8'h01, 8'h00);
        wr(8'h01, 8'h01);
        chk({7'h00, soft_rst_o}, 8'h01);
        @(negedge clk_i);
        chk({7'h00, soft_rst_o}, 8'h00);
        chk({opmode_o, lsfs_only_o, role_dev_o}, 8'h00);
        rd_chk(8'h01, 8'h00);
        rd_chk(8'h02, 8'h00);
        // mid-run reset drops a forced setup back to defaults
        wr(8'h02, 8'h52);
        chk({cd_enter_o, role_host_o, lsfs_only_o}, 8'h07);
        rst_i = 1'b1;
        @(negedge clk_i);
        rst_i = 1'b0;
        chk({opmode_o, lsfs_only_o, role_host_o}, 8'h00);
        chk({cd_enter_o, cfg_ack_o, soft_rst_o}, 8'h00);
        rd_chk(8'h02, 8'h00);
        tally_and_finish();
    end
endmodule : testbench
